/* File: brg_pkg.sv */
// shared constants for the brake resistor thermal guard
package brg_pkg;
    localparam int          BRG_CLK_MHZ       = 125;
    // estimate scaling: full scale equals 100 percent
    localparam logic [15:0] BRG_FULL          = 16'h2710;
    localparam logic [15:0] BRG_ALARM_LVL     = 16'h1D4C;
    localparam logic [15:0] BRG_RELEASE_LVL   = 16'h251C;
    localparam logic [6:0]  BRG_PCT_DIV       = 7'h64;
    // model update period, short so a full-scale climb fits a short run
    localparam int          BRG_TICK_US       = 1;
    localparam int          BRG_TICK_CYC      = BRG_TICK_US * BRG_CLK_MHZ;
    // bus voltage thresholds per rating
    localparam logic [11:0] BRG_VTH_200       = 12'h186;
    localparam logic [11:0] BRG_VTH_400       = 12'h30C;
    localparam logic [11:0] BRG_VTH_690       = 12'h460;
    // register map
    localparam logic [3:0]  BRG_REG_DUR       = 4'h0;
    localparam logic [3:0]  BRG_REG_INTERVAL  = 4'h1;
    localparam logic [3:0]  BRG_REG_MODE      = 4'h2;
    localparam logic [3:0]  BRG_REG_RATING    = 4'h3;
    localparam logic [3:0]  BRG_REG_TEMP      = 4'h4;
    localparam logic [3:0]  BRG_REG_STATUS    = 4'h5;
    localparam logic [3:0]  BRG_REG_EVENTS    = 4'h6;
    localparam logic [3:0]  BRG_REG_CLEAR     = 4'h7;
    localparam logic [3:0]  BRG_REG_ENABLE    = 4'h8;
    // reset values
    localparam logic [15:0] BRG_DUR_RST       = 16'h0000;
    localparam logic [15:0] BRG_INTERVAL_RST  = 16'h0000;
    localparam logic [1:0]  BRG_MODE_RST      = 2'h0;
    localparam logic [1:0]  BRG_RATING_RST    = 2'h0;
    // event bits
    localparam int          BRG_EV_ALARM      = 0;
    localparam int          BRG_EV_TRIP       = 1;
    localparam int          BRG_EV_INHIBIT    = 2;
    localparam int          BRG_EV_RELEASE    = 3;
    localparam int          BRG_EV_N          = 4;
    typedef enum logic [1:0] {
        BRG_ST_NORMAL  = 2'b00,
        BRG_ST_INHIBIT = 2'b01,
        BRG_ST_TRIPPED = 2'b10
    } brg_state_t;
endpackage

/* File: brg_model.sv */
// thermal model of the braking resistor, stepped once per tick
`timescale 1ns/1ps
module brg_model
    import brg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        tick,
    input  wire logic        conducting,
    input  wire logic [15:0] overload_duration_setting,
    input  wire logic [15:0] overload_repeat_interval_setting,
    output logic      [15:0] resistor_temp_estimate
);
    logic [15:0] next_temp;
    logic [16:0] rise;
    logic [16:0] fall;
    logic [16:0] up;

    // rates: full scale reached in duration ticks, emptied in interval ticks
    always_comb begin
        rise = (overload_duration_setting == 16'h0000) ? {1'b0, BRG_FULL}
             : {1'b0, BRG_FULL / overload_duration_setting};
        if (rise == 17'h00000) begin
            rise = 17'h00001;
        end
        fall = (overload_repeat_interval_setting == 16'h0000) ? {1'b0, BRG_FULL}
             : {1'b0, BRG_FULL / overload_repeat_interval_setting};
        if (fall == 17'h00000) begin
            fall = 17'h00001;
        end
        up = {1'b0, resistor_temp_estimate} + rise;
        next_temp = resistor_temp_estimate;
        if (tick) begin
            if (conducting) begin
                next_temp = (up > {1'b0, BRG_FULL}) ? BRG_FULL : up[15:0];
            end else begin
                next_temp = ({1'b0, resistor_temp_estimate} < fall) ? 16'h0000
                          : 16'(resistor_temp_estimate - fall[15:0]);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resistor_temp_estimate <= 16'h0000;
        end else begin
            resistor_temp_estimate <= next_temp;
        end
    end
endmodule

/* File: brg_guard.sv */
// brake resistor thermal guard: chopper, model, alarm, trip or inhibit, registers
// How it works
// - a thermal model keeps the resistor temperature as hundredths of a percent, 0 ambient, 10000 the limit.
// - the overload alarm is high while the estimate exceeds 75 percent and the braking transistor is on.
// - in protection modes 0 and 1 the resistor overload trip is raised when the estimate reaches full scale.
// - the protection mode resets to 0, trip on overload.
// - in protection modes 2 and 3 reaching full scale raises no trip.
// - in modes 2 and 3 the braking transistor is forced off at full scale until the estimate is below 95 percent.
// - once below 95 percent normal braking transistor switching is allowed again.
// - the braking transistor turns on when the bus voltage reaches 390, 780 or 1120 V by rating.
`timescale 1ns/1ps
module brg_guard
    import brg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic [11:0] dc_bus_volts,
    input  wire logic        trip_reset,
    output logic             braking_transistor,
    output logic             overload_alarm,
    output logic             resistor_overload_trip,
    output logic             irq
);
    logic [15:0]         overload_duration_setting;
    logic [15:0]         overload_repeat_interval_setting;
    logic [1:0]          protection_mode_setting;
    logic [1:0]          rating;
    logic [15:0]         next_dur;
    logic [15:0]         next_interval;
    logic [1:0]          next_mode;
    logic [1:0]          next_rating;
    logic [15:0]         resistor_temp_estimate;
    logic [31:0]         tick_cnt;
    logic [31:0]         next_tick_cnt;
    logic                tick;
    brg_state_t          state;
    brg_state_t          next_state;
    logic [11:0]         vth;
    logic                want_on;
    logic                next_brake;
    logic                next_alarm;
    logic [BRG_EV_N-1:0] events;
    logic [BRG_EV_N-1:0] next_events;
    logic [BRG_EV_N-1:0] ev_pulse;
    logic [BRG_EV_N-1:0] irq_en;
    logic [BRG_EV_N-1:0] next_irq_en;
    logic [31:0]         next_rdata;
    logic                alarm_prev;
    logic [BRG_EV_N-1:0] clear_mask;

    // configuration registers
    always_comb begin
        next_dur      = overload_duration_setting;
        next_interval = overload_repeat_interval_setting;
        next_mode     = protection_mode_setting;
        next_rating   = rating;
        next_irq_en   = irq_en;
        if (wr) begin
            case (addr)
                BRG_REG_DUR: begin
                    next_dur = wdata[15:0];
                end
                BRG_REG_INTERVAL: begin
                    next_interval = wdata[15:0];
                end
                BRG_REG_MODE: begin
                    next_mode = wdata[1:0];
                end
                BRG_REG_RATING: begin
                    next_rating = wdata[1:0];
                end
                BRG_REG_ENABLE: begin
                    next_irq_en = wdata[BRG_EV_N-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overload_duration_setting        <= BRG_DUR_RST;
            overload_repeat_interval_setting <= BRG_INTERVAL_RST;
            protection_mode_setting          <= BRG_MODE_RST;
            rating                           <= BRG_RATING_RST;
            irq_en                           <= '0;
        end else begin
            overload_duration_setting        <= next_dur;
            overload_repeat_interval_setting <= next_interval;
            protection_mode_setting          <= next_mode;
            rating                           <= next_rating;
            irq_en                           <= next_irq_en;
        end
    end

    // model tick generator
    always_comb begin
        tick          = (tick_cnt == 32'(BRG_TICK_CYC - 1));
        next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    brg_model u_model (
        .clk                              (clk),
        .resetn                           (resetn),
        .tick                             (tick),
        .conducting                       (braking_transistor),
        .overload_duration_setting        (overload_duration_setting),
        .overload_repeat_interval_setting (overload_repeat_interval_setting),
        .resistor_temp_estimate           (resistor_temp_estimate)
    );

    // protection state and chopper
    always_comb begin
        case (rating)
            2'h1:    vth = BRG_VTH_400;
            2'h2:    vth = BRG_VTH_690;
            default: vth = BRG_VTH_200;
        endcase
        want_on    = (dc_bus_volts >= vth);
        next_state = state;
        case (state)
            BRG_ST_NORMAL: begin
                if (resistor_temp_estimate >= BRG_FULL) begin
                    // trip in modes 0 and 1
                    // no trip in modes 2 and 3
                    next_state = protection_mode_setting[1] ? BRG_ST_INHIBIT : BRG_ST_TRIPPED;
                end
            end
            BRG_ST_INHIBIT: begin
                if (resistor_temp_estimate < BRG_RELEASE_LVL) begin
                    next_state = BRG_ST_NORMAL;
                end
            end
            BRG_ST_TRIPPED: begin
                if (trip_reset && resistor_temp_estimate < BRG_FULL) begin
                    next_state = BRG_ST_NORMAL;
                end
            end
            default: begin
                next_state = BRG_ST_NORMAL;
            end
        endcase
        next_brake = want_on && (next_state == BRG_ST_NORMAL);
        // alarm above 75 percent while active
        next_alarm = next_brake && (resistor_temp_estimate > BRG_ALARM_LVL);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state                  <= BRG_ST_NORMAL;
            braking_transistor     <= 1'b0;
            overload_alarm         <= 1'b0;
            resistor_overload_trip <= 1'b0;
        end else begin
            state                  <= next_state;
            braking_transistor     <= next_brake;
            overload_alarm         <= next_alarm;
            resistor_overload_trip <= (next_state == BRG_ST_TRIPPED);
        end
    end

    // sticky events, set wins over clear
    always_comb begin
        ev_pulse                 = '0;
        ev_pulse[BRG_EV_ALARM]   = next_alarm && !alarm_prev;
        ev_pulse[BRG_EV_TRIP]    = (next_state == BRG_ST_TRIPPED) && (state != BRG_ST_TRIPPED);
        ev_pulse[BRG_EV_INHIBIT] = (next_state == BRG_ST_INHIBIT) && (state != BRG_ST_INHIBIT);
        ev_pulse[BRG_EV_RELEASE] = (next_state == BRG_ST_NORMAL) && (state == BRG_ST_INHIBIT);
        clear_mask               = (wr && addr == BRG_REG_CLEAR) ? wdata[BRG_EV_N-1:0] : '0;
        next_events              = (events & ~clear_mask) | ev_pulse;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            events     <= '0;
            alarm_prev <= 1'b0;
            irq        <= 1'b0;
        end else begin
            events     <= next_events;
            alarm_prev <= next_alarm;
            irq        <= |(next_events & next_irq_en);
        end
    end

    // read port
    always_comb begin
        next_rdata = 32'h00000000;
        if (rd) begin
            case (addr)
                BRG_REG_DUR:      next_rdata = {16'h0000, overload_duration_setting};
                BRG_REG_INTERVAL: next_rdata = {16'h0000, overload_repeat_interval_setting};
                BRG_REG_MODE:     next_rdata = {30'h00000000, protection_mode_setting};
                BRG_REG_RATING:   next_rdata = {30'h00000000, rating};
                BRG_REG_TEMP:     next_rdata = {16'h0000, resistor_temp_estimate};
                BRG_REG_STATUS:   next_rdata = {27'h0000000, state, overload_alarm,
                                                resistor_overload_trip, braking_transistor};
                BRG_REG_EVENTS:   next_rdata = {28'h0000000, events};
                BRG_REG_ENABLE:   next_rdata = {28'h0000000, irq_en};
                default:          next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

/* File: brg_bus_model.sv */
// far side: dc bus with the braking transistor dumping into the resistor
`timescale 1ns/1ps
module brg_bus_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        gate,
    input  wire logic        stiff,
    input  wire logic [11:0] target,
    output logic      [11:0] volts
);
    localparam logic [11:0] DROP = 12'h004;
    logic [11:0] next_volts;
    // stiff regen holds the bus, else conduction pulls it down
    always_comb begin
        next_volts = target;
        if (gate && !stiff)
            next_volts = (volts > DROP) ? volts - DROP : 12'h000;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            volts <= 12'h000;
        else
            volts <= next_volts;
    end
endmodule

/* File: brg_guard_asserts.sv */
// assertion checker for the brake resistor thermal guard
`timescale 1ns/1ps
module brg_guard_asserts
    import brg_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [11:0] dc_bus_volts,
    input wire logic        trip_reset,
    input wire logic        braking_transistor,
    input wire logic        overload_alarm,
    input wire logic        resistor_overload_trip,
    input wire logic        irq
);
    logic [1:0]  mode, next_mode, rating, next_rating;
    logic [11:0] vth;
    // shadow of the mode and rating settings
    always_comb begin
        next_mode   = mode;
        next_rating = rating;
        if (wr && addr == BRG_REG_MODE)
            next_mode = wdata[1:0];
        if (wr && addr == BRG_REG_RATING)
            next_rating = wdata[1:0];
        vth = (rating == 2'h1) ? BRG_VTH_400 : (rating == 2'h2) ? BRG_VTH_690 : BRG_VTH_200;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode   <= BRG_MODE_RST;
            rating <= BRG_RATING_RST;
        end else begin
            mode   <= next_mode;
            rating <= next_rating;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_alarm; overload_alarm |-> braking_transistor; endproperty
    property p_trip_off; resistor_overload_trip |-> !braking_transistor; endproperty
    property p_trip_hold; resistor_overload_trip && !trip_reset |=> resistor_overload_trip; endproperty
    property p_trip_exit; $fell(resistor_overload_trip) |-> $past(trip_reset); endproperty
    property p_trip_mode; $rose(resistor_overload_trip) |-> !$past(mode[1]); endproperty
    property p_volts; braking_transistor |-> $past(dc_bus_volts) >= $past(vth); endproperty
    property p_mode_rd; $past(rd) && $past(addr) == BRG_REG_MODE |-> rdata[1:0] == $past(mode); endproperty
    property p_temp_rd; $past(rd) && $past(addr) == BRG_REG_TEMP |-> rdata <= {16'h0000, BRG_FULL}; endproperty
    a_alarm: assert property (p_alarm) else $error("alarm while off");
    a_trip_off: assert property (p_trip_off) else $error("braking while tripped");
    a_trip_hold: assert property (p_trip_hold) else $error("trip dropped");
    a_trip_exit: assert property (p_trip_exit) else $error("trip left unasked");
    a_trip_mode: assert property (p_trip_mode) else $error("trip in mode 2 or 3");
    a_volts: assert property (p_volts) else $error("braking below threshold");
    a_mode_rd: assert property (p_mode_rd) else $error("mode readback");
    a_temp_rd: assert property (p_temp_rd) else $error("estimate above full");
    c_trip: cover property ($rose(resistor_overload_trip));
    c_inhibit: cover property ($fell(braking_transistor) && mode[1]);
    c_alarm: cover property ($rose(overload_alarm));
endmodule
bind brg_guard brg_guard_asserts chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dc_bus_volts(dc_bus_volts), .trip_reset(trip_reset), .irq(irq),
    .braking_transistor(braking_transistor), .overload_alarm(overload_alarm),
    .resistor_overload_trip(resistor_overload_trip));

/* File: tb.sv */
// self-checking bench for the brake resistor thermal guard
`timescale 1ns/1ps
module tb
    import brg_pkg::*;
;
    logic        clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, trip_reset = 1'b0, stiff = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'hBE478342;
    logic [11:0] volts, target = 12'h000;
    logic        brake, alarm, trip, irq;
    int          n_fail = 0, tests_run = 0;
    always #4 clk = ~clk;
    brg_guard uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .dc_bus_volts(volts), .trip_reset(trip_reset), .braking_transistor(brake), .overload_alarm(alarm),
        .resistor_overload_trip(trip), .irq(irq));
    brg_bus_model bus (.clk(clk), .resetn(resetn), .gate(brake), .stiff(stiff), .target(target), .volts(volts));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic [11:0] vth(input int r);
        return (r == 0) ? BRG_VTH_200 : (r == 1) ? BRG_VTH_400 : BRG_VTH_690;
    endfunction
    task automatic report_and_stop();
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_for(input int sel, input logic val, input int lim);
        for (int i = 0; i <= lim; i++) begin
            if ((sel == 0 ? brake : sel == 1 ? alarm : trip) === val)
                return;
            @(posedge clk);
            #1;
        end
        n_fail++;
        $display("[FAIL] wait %0d expected %b seen timeout", sel, val);
        report_and_stop();
    endtask
    task automatic clear_trip();
        @(posedge clk);
        trip_reset <= 1'b1;
        wait_for(2, 1'b0, 2 * BRG_TICK_CYC);
        @(posedge clk);
        trip_reset <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        reg_rd(BRG_REG_MODE, rv);
        chk("mode", rv, 32'h0);
        reg_rd(BRG_REG_TEMP, rv);
        chk("temp", rv, 32'h0);
        reg_rd(4'hF, rv);
        chk("unmapped", rv, 32'h0);
        reg_wr(BRG_REG_DUR, 32'h3);
        reg_wr(BRG_REG_INTERVAL, 32'h1);
        reg_wr(BRG_REG_ENABLE, 32'hF);
        for (int r = 0; r < 3; r++) begin
            reg_wr(BRG_REG_RATING, r);
            @(posedge clk);
            target <= vth(r) - 12'h001;
            repeat (4) @(posedge clk);
            #1;
            chk("brake low", brake, 1'b0);
            seed = lfsr(seed);
            @(posedge clk);
            target <= vth(r) + seed[5:0];
            repeat (3) @(posedge clk);
            #1;
            chk("brake high", brake, 1'b1);
            @(posedge clk);
            stiff <= 1'b0;
            wait_for(0, 1'b0, 200);
            @(posedge clk);
            stiff  <= 1'b1;
            target <= 12'h000;
        end
        reg_wr(BRG_REG_RATING, 32'h0);
        @(posedge clk);
        target <= BRG_VTH_200;
        wait_for(1, 1'b1, 4 * BRG_TICK_CYC);
        reg_rd(BRG_REG_TEMP, rv);
        chk("temp alarm", rv, 3 * (BRG_FULL / 3));
        wait_for(2, 1'b1, 2 * BRG_TICK_CYC);
        chk("brake trip", brake, 1'b0);
        reg_rd(BRG_REG_TEMP, rv);
        chk("temp full", rv, BRG_FULL);
        chk("irq", irq, 1'b1);
        reg_wr(BRG_REG_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk("irq masked", irq, 1'b0);
        reg_wr(BRG_REG_CLEAR, 32'hF);
        reg_rd(BRG_REG_EVENTS, rv);
        chk("alarm event", rv[0], 1'b0);
        reg_wr(BRG_REG_ENABLE, 32'hF);
        clear_trip();
        reg_wr(BRG_REG_DUR, 32'h1);
        for (int m = 1; m < 4; m++) begin
            reg_wr(BRG_REG_INTERVAL, (m > 1) ? 32'hA : 32'h1);
            reg_wr(BRG_REG_MODE, m);
            wait_for(0, 1'b1, 8);
            wait_for(0, 1'b0, 2 * BRG_TICK_CYC);
            repeat (2) @(posedge clk);
            #1;
            chk("trip", trip, m < 2);
            reg_rd(BRG_REG_STATUS, rv);
            chk("status", rv, (m < 2) ? 32'h00000012 : 32'h00000008);
            reg_rd(BRG_REG_TEMP, rv);
            chk("temp full", rv, BRG_FULL);
            if (m < 2) begin
                clear_trip();
            end else begin
                wait_for(0, 1'b1, 2 * BRG_TICK_CYC);
                reg_rd(BRG_REG_TEMP, rv);
                chk("temp release", rv, BRG_FULL - BRG_FULL / 10);
            end
        end
        report_and_stop();
    end
endmodule
